//--- common/port_pkg.sv
package port_pkg;

    // Port geometry
    localparam int PORT_W = 8;

    // Register byte addresses on the Wishbone bus (printed offsets are odd,
    // so they are kept as indices and the byte address is four times that)
    localparam logic [15:0] DIR_IDX = 16'hffb5;
    localparam logic [15:0] DATA_IDX = 16'hffb7;
    localparam logic [17:0] DIR_ADDR = {DIR_IDX, 2'b00};
    localparam logic [17:0] DATA_ADDR = {DATA_IDX, 2'b00};
    localparam int ADDR_W = 18;

    // Reset values and fixed read values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DIR_READ_VAL = 8'hff;
    localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;

    // Pin positions
    localparam int PIN_TMR_A_CLK = 0;
    localparam int PIN_TMR_A_OUT = 1;
    localparam int PIN_TMR_A_RST = 2;
    localparam int PIN_TMR_B_CLK = 3;
    localparam int PIN_TMR_B_OUT = 4;
    localparam int PIN_TMR_B_RST = 5;
    localparam int PIN_PWM_A = 6;
    localparam int PIN_PWM_B = 7;

    // Peripheral output requests toward the pins
    typedef struct packed {
        logic pwm_b_en;
        logic pwm_b_val;
        logic pwm_a_en;
        logic pwm_a_val;
        logic tmr_b_en;
        logic tmr_b_val;
        logic tmr_a_en;
        logic tmr_a_val;
    } periph_out_t;

    // Host interrupt request levels, slave mode only
    typedef struct packed {
        logic irq_c;
        logic irq_a;
        logic irq_b;
    } host_irq_t;

    // Timer inputs taken from the pins
    typedef struct packed {
        logic timer_b_reset_input;
        logic timer_b_clock_input;
        logic timer_a_reset_input;
        logic timer_a_clock_input;
    } timer_in_t;

endpackage : port_pkg

//--- design/sync_bit.sv
`timescale 1ns/10ps
// Two flip-flop synchroniser for one pin level
module sync_bit
    import port_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Level
    input wire logic d_i,
    output logic q_o
);

    logic meta_r; // First stage, read only by the second

    // Two stages clear on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule : sync_bit

//--- design/pin_cell.sv
`timescale 1ns/10ps
// One port pin: output select and enable
module pin_cell
    import port_pkg::*;
(
    // Port state
    input wire logic dir_i,
    input wire logic data_i,
    // Peripheral claim
    input wire logic own_i,
    input wire logic own_val_i,
    // Next pin drive
    output logic out_nxt_o,
    output logic oe_nxt_o
);

    // Peripheral wins over the port registers
    assign out_nxt_o = own_i ? own_val_i : data_i;
    // Driven if peripheral owns it or direction is output
    assign oe_nxt_o = own_i | dir_i;

endmodule : pin_cell

//--- design/io_port.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
// Function
// RULE1: Direction bit one drives pin, zero inputs
// RULE2: Direction register reads back all ones
// RULE3: Reset and hardware standby clear direction
// RULE4: Software standby keeps direction and outputs
// RULE5: Software standby drops peripheral pin ownership; code keeps slave mode irq claims
// RULE6: Output pins read data register bit
// RULE7: Input pins read synchronised pin level
// RULE8: Read selection same for peripheral pins
// RULE9: Data register read/write, cleared, kept
// RULE10: Unclaimed pins stay general purpose
// RULE11: Pin map of timers and PWM
// RULE12: Slave mode bits 5..3 irq, output pins only
// RULE13: Unowned output pins drive data bit
module io_port
    import port_pkg::*;
#(
    parameter int WIDTH = PORT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Standby and mode
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    input wire logic slave_mode_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Peripherals
    input wire periph_out_t periph_i,
    input wire host_irq_t host_irq_i,
    output timer_in_t timer_in_o,
    output logic periph_reset_o,
    // Pins
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o
);

    // Port registers and their next values
    logic [WIDTH-1:0] dir_r; // Direction, one is output
    logic [WIDTH-1:0] data_r; // Output data register
    logic [WIDTH-1:0] dir_nxt; // Direction after this edge
    logic [WIDTH-1:0] data_nxt; // Data after this edge
    // Pin side
    logic [WIDTH-1:0] pin_s; // Synchronised pin levels
    logic [WIDTH-1:0] own; // Pin claimed by a peripheral
    logic [WIDTH-1:0] own_val; // Value the claimer drives
    logic [WIDTH-1:0] out_nxt; // Pin value for the next edge
    logic [WIDTH-1:0] oe_nxt; // Pin enable for the next edge
    // Bus side
    logic [WIDTH-1:0] port_read; // Port read value
    logic [31:0] rd_nxt; // Read word for the next ack
    logic clr; // Reset or hardware standby
    logic req; // New bus request
    logic hit_dir; // Address is the direction register
    logic hit_data; // Address is the data register
    logic wr_dir; // Direction write this cycle
    logic wr_data; // Data write this cycle
    // Slave mode host requests
    logic irq_slot; // Slave mode irq pins bits 5..3
    logic [WIDTH-1:0] irq_mask; // Pins that may carry a request
    logic [WIDTH-1:0] irq_val; // Request levels at their pin positions

    // Clearing source for the registers
    assign clr = rst_i | hw_standby_i; // RULE3

    // Request is taken once; ack drops in the next cycle
    assign req = cyc_i & stb_i & ~ack_o;
    assign hit_dir = (adr_i == DIR_ADDR);
    assign hit_data = (adr_i == DATA_ADDR);
    // Data sits in byte lane 0
    assign wr_dir = req & we_i & hit_dir & sel_i[0];
    assign wr_data = req & we_i & hit_data & sel_i[0];

    // Register next values; standby does not touch them
    assign dir_nxt = wr_dir ? dat_i[WIDTH-1:0] : dir_r; // RULE1 RULE4
    assign data_nxt = wr_data ? dat_i[WIDTH-1:0] : data_r; // RULE9

    // Slave mode puts irq outputs on bits 5..3
    assign irq_slot = slave_mode_i; // RULE12

    // Request slots share the pins of the second timer
    always_comb begin
        irq_mask = '0;
        irq_val = '0;
        // Levels sit at their pins in any mode; the mask gates them
        irq_val[PIN_TMR_B_RST] = host_irq_i.irq_c;
        irq_val[PIN_TMR_B_OUT] = host_irq_i.irq_a;
        irq_val[PIN_TMR_B_CLK] = host_irq_i.irq_b;
        if (irq_slot) begin // RULE12
            irq_mask[PIN_TMR_B_RST] = 1'b1;
            irq_mask[PIN_TMR_B_OUT] = 1'b1;
            irq_mask[PIN_TMR_B_CLK] = 1'b1;
        end
    end

    // Peripheral ownership; timer and PWM claims released in software standby, slave mode irq claims kept
    // Irq pins drive only where direction is output, per pin map
    always_comb begin
        own = '0;
        own_val = '0;
        if (!sw_standby_i) begin // RULE5
            own[PIN_PWM_B] = periph_i.pwm_b_en; // RULE11
            own_val[PIN_PWM_B] = periph_i.pwm_b_val;
            own[PIN_PWM_A] = periph_i.pwm_a_en; // RULE11
            own_val[PIN_PWM_A] = periph_i.pwm_a_val;
            own[PIN_TMR_B_OUT] = periph_i.tmr_b_en; // RULE11
            own_val[PIN_TMR_B_OUT] = periph_i.tmr_b_val;
            own[PIN_TMR_A_OUT] = periph_i.tmr_a_en; // RULE11
            own_val[PIN_TMR_A_OUT] = periph_i.tmr_a_val;
        end
        // Irq output on a pin with direction set, timer out still wins
        for (int i = 0; i < WIDTH; i++) begin
            if (irq_mask[i] && dir_r[i] && !own[i]) begin // RULE12
                own[i] = 1'b1;
                own_val[i] = irq_val[i];
            end
        end
    end

    // One pin cell per bit
    for (genvar g = 0; g < WIDTH; g++) begin : g_pin
        pin_cell u_cell (
            .dir_i(dir_r[g]),
            .data_i(data_r[g]),
            .own_i(own[g]),
            .own_val_i(own_val[g]),
            .out_nxt_o(out_nxt[g]), // RULE13
            .oe_nxt_o(oe_nxt[g]) // RULE1 RULE10
        );
        sync_bit u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .d_i(pin_i[g]),
            .q_o(pin_s[g]) // RULE7
        );
    end

    // Output pins read the register, inputs the pin, for every pin
    assign port_read = (dir_r & data_r) | (~dir_r & pin_s); // RULE6 RULE7 RULE8

    // Read mux; unmapped reads return zero
    assign rd_nxt = hit_dir ? {24'h000000, DIR_READ_VAL} : // RULE2
                    hit_data ? {24'h000000, port_read} : UNMAPPED_VAL;

    // Port registers
    always_ff @(posedge clk_i) begin
        if (clr) begin
            dir_r <= DIR_RST; // RULE3
            data_r <= DATA_RST; // RULE9
        end else begin
            dir_r <= dir_nxt;
            data_r <= data_nxt;
        end
    end

    // Bus answer: one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= req;
            dat_o <= req ? rd_nxt : '0;
        end
    end

    // Registered pin drive and peripheral side
    always_ff @(posedge clk_i) begin
        if (clr) begin
            pin_o <= '0;
            pin_oe_o <= '0;
            timer_in_o <= '0;
            periph_reset_o <= 1'b1;
        end else begin
            pin_o <= out_nxt;
            pin_oe_o <= oe_nxt;
            timer_in_o.timer_b_reset_input <= pin_s[PIN_TMR_B_RST]; // RULE11
            timer_in_o.timer_b_clock_input <= pin_s[PIN_TMR_B_CLK];
            timer_in_o.timer_a_reset_input <= pin_s[PIN_TMR_A_RST];
            timer_in_o.timer_a_clock_input <= pin_s[PIN_TMR_A_CLK];
            periph_reset_o <= sw_standby_i; // RULE5
        end
    end

    // Assertions, one clock domain, cleared by the bus reset except the two hardware standby ones

    // Direction reads never show the stored bits
    a_dir_read_ones: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (req && !we_i && hit_dir) |=> (ack_o && dat_o[WIDTH-1:0] == DIR_READ_VAL))
        else $error("direction read not all ones");

    // Every request gets one ack, which drops in the next cycle
    sequence s_bus_take;
        req;
    endsequence
    sequence s_bus_answer;
        ack_o ##1 !ack_o;
    endsequence
    a_bus_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_take |=> s_bus_answer)
        else $error("bus ack not a single pulse");

    // Hardware standby clears both registers; no reset gating on purpose
    a_clear_dir: assert property (@(posedge clk_i) // RULE3
        hw_standby_i |=> (dir_r == DIR_RST && data_r == DATA_RST))
        else $error("standby did not clear registers");

    // Hardware standby also releases every pin and holds the peripherals
    a_clear_pins: assert property (@(posedge clk_i) // RULE3
        hw_standby_i |=> (pin_oe_o == '0 && periph_reset_o))
        else $error("standby left a pin driven");

    // Software standby leaves the direction register alone
    a_sw_keep: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        (sw_standby_i && !hw_standby_i && !wr_dir) |=> $stable(dir_r))
        else $error("direction lost in software standby");

    // Outside slave mode, software standby hands every pin back to the port registers
    a_sw_release: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        (sw_standby_i && !hw_standby_i && !irq_slot) |=> (pin_oe_o == $past(dir_r)))
        else $error("peripheral kept pin in standby");

    // Peripherals are held in reset through software standby
    a_sw_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        sw_standby_i |=> periph_reset_o)
        else $error("peripherals not held in standby");

    // Port read picks register or pin by direction, owned pins too
    a_read_data: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6 RULE7 RULE8
        (req && !we_i && hit_data) |=>
        (dat_o[7:0] == (($past(dir_r) & $past(data_r)) | (~$past(dir_r) & $past(pin_s)))))
        else $error("port read mismatch");

    // Data writes land at the taking edge
    sequence s_write_data;
        req && we_i && hit_data && sel_i[0] && !hw_standby_i;
    endsequence
    a_data_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        s_write_data |=> (data_r == $past(dat_i[7:0])))
        else $error("data write lost");

    // Direction writes land at the taking edge
    sequence s_write_dir;
        req && we_i && hit_dir && sel_i[0] && !hw_standby_i;
    endsequence
    a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        s_write_dir |=> (dir_r == $past(dat_i[WIDTH-1:0])))
        else $error("direction write lost");

    // A write without byte lane 0 changes nothing
    a_write_lane: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        (req && we_i && !sel_i[0] && !hw_standby_i) |=> ($stable(dir_r) && $stable(data_r)))
        else $error("write without lane 0 took effect");

    // Output pin with no claimer shows its data bit
    a_plain_out: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        (!own[PIN_TMR_A_CLK] && dir_r[PIN_TMR_A_CLK] && !clr) |=>
        (pin_oe_o[PIN_TMR_A_CLK] && pin_o[PIN_TMR_A_CLK] == $past(data_r[PIN_TMR_A_CLK])))
        else $error("pin 0 not driven from data");

    // All inputs and no claimer: nothing driven
    a_input_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (dir_r == '0 && own == '0 && !clr) |=> (pin_oe_o == '0))
        else $error("input pin driven");

    // Pin with no output function follows its direction bit
    a_free_pin: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        !clr |=> (pin_oe_o[PIN_TMR_A_RST] == $past(dir_r[PIN_TMR_A_RST])))
        else $error("free pin not under port control");

    // Second PWM output reaches bit 7 outside standby
    a_pwm_owns: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        (periph_i.pwm_b_en && !sw_standby_i && !clr) |=>
        (pin_oe_o[PIN_PWM_B] && pin_o[PIN_PWM_B] == $past(periph_i.pwm_b_val)))
        else $error("second pwm output not on its pin");

    // First timer output reaches bit 1 outside standby
    a_timer_owns: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        (periph_i.tmr_a_en && !sw_standby_i && !clr) |=>
        (pin_oe_o[PIN_TMR_A_OUT] && pin_o[PIN_TMR_A_OUT] == $past(periph_i.tmr_a_val)))
        else $error("first timer output not on its pin");

    // Timer inputs follow their synchronised pins, one register later
    a_timer_in: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        !clr |=> (timer_in_o.timer_b_reset_input == $past(pin_s[PIN_TMR_B_RST])
        && timer_in_o.timer_a_clock_input == $past(pin_s[PIN_TMR_A_CLK])))
        else $error("timer input not from its pin");

    // Slave mode request pin: driven with the request when set as output
    sequence s_irq_drive;
        irq_slot && dir_r[PIN_TMR_B_RST] && !clr;
    endsequence
    a_irq_drive: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        s_irq_drive |=> (pin_oe_o[PIN_TMR_B_RST]
        && pin_o[PIN_TMR_B_RST] == $past(host_irq_i.irq_c)))
        else $error("host request not on its pin");

    // Slave mode request pin set as input stays undriven
    a_irq_input: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        (irq_slot && !dir_r[PIN_TMR_B_RST] && !clr) |=> !pin_oe_o[PIN_TMR_B_RST])
        else $error("slave mode input pin driven");

endmodule : io_port

//--- sim/pin_partner.sv
`timescale 1ns/10ps
// Far side of the port: what the board puts on each pin
module pin_partner
    import port_pkg::*;
(
    // From the port
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] oe_i,
    // Level the board drives on released pins
    input wire logic [7:0] level_i,
    // Resolved wire level
    output logic [7:0] pin_i_o
);
    // Driven pins show the port's value, released ones the board's
    assign pin_i_o = (pin_o_i & oe_i) | (level_i & ~oe_i);
endmodule : pin_partner

//--- sim/io_port_test.sv
`timescale 1ns/10ps
// Register and pin level checks of the port
module io_port_test;
    import port_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_standby_i = 1'b0, sw_standby_i = 1'b0, slave_mode_i = 1'b0;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [ADDR_W-1:0] adr_i = 18'h00000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, periph_reset_o;
    periph_out_t periph_i = 8'h00;
    host_irq_t host_irq_i = 3'h0;
    timer_in_t timer_in_o;
    logic [7:0] pin_i, pin_o, pin_oe_o;
    logic [7:0] ext_lvl = 8'h3c; // Board level on released pins
    int n_errors = 0, compares = 0;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    io_port dut (.clk_i, .rst_i, .hw_standby_i, .sw_standby_i, .slave_mode_i,
        .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .periph_i, .host_irq_i, .timer_in_o, .periph_reset_o,
        .pin_i, .pin_o, .pin_oe_o);

    pin_partner far (.pin_o_i(pin_o), .oe_i(pin_oe_o), .level_i(ext_lvl), .pin_i_o(pin_i));

    // One classic cycle; request held until ack is sampled
    task wb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
            input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            $display("wrong value ack expected 1 seen none");
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    // Compare one value
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Read and compare
    task rdchk(input logic [ADDR_W-1:0] a, input string nm, input logic [31:0] e);
        wb(1'b0, a, 8'h00, 4'hf);
        chk(nm, e, rd);
    endtask : rdchk

    // Pin register plus two synchroniser stages, with margin
    task settle;
        repeat (4) @(posedge clk_i);
    endtask : settle

    // Verdict
    task final_report;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // Watchdog, far beyond the hundred or so cycles needed
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        final_report;
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("oe after reset", 32'h0, {24'h0, pin_oe_o});
        rdchk(DIR_ADDR, "dir read", 32'h0000_00ff);
        wb(1'b1, DIR_ADDR, 8'hff, 4'h1);
        rdchk(DATA_ADDR, "data reset", 32'h0);
        $display("test reset done");
        // Mixed directions, refused writes, unmapped place
        wb(1'b1, DATA_ADDR, 8'ha5, 4'h1);
        wb(1'b1, DIR_ADDR, 8'h0f, 4'h1);
        settle;
        chk("oe mixed", 32'h0f, {24'h0, pin_oe_o});
        chk("pin out", 32'h05, {24'h0, pin_o & pin_oe_o});
        rdchk(DATA_ADDR, "mixed read", 32'h35);
        rdchk(DIR_ADDR, "dir read", 32'h0000_00ff);
        wb(1'b1, DATA_ADDR, 8'h00, 4'h0);
        wb(1'b1, 18'h00100, 8'h00, 4'h1);
        rdchk(18'h00100, "unmapped", 32'h0);
        rdchk(DATA_ADDR, "data kept", 32'h35);
        $display("test directions done");
        // Timer and PWM claims: bit 7 and bit 1 driven, bits 0 and 3 inputs
        wb(1'b1, DIR_ADDR, 8'h02, 4'h1);
        periph_i <= periph_out_t'(8'hc3);
        ext_lvl <= 8'h09;
        settle;
        chk("oe periph", 32'h82, {24'h0, pin_oe_o});
        chk("pin periph", 32'h82, {24'h0, pin_o & pin_oe_o});
        chk("timer in", 32'h5, {28'h0, timer_in_o});
        chk("periph reset", 32'h0, {31'h0, periph_reset_o});
        rdchk(DATA_ADDR, "periph read", 32'h89);
        $display("test peripherals done");
        // Software standby drops claims, keeps registers
        sw_standby_i <= 1'b1;
        settle;
        chk("oe standby", 32'h02, {24'h0, pin_oe_o});
        chk("pin standby", 32'h00, {24'h0, pin_o & pin_oe_o});
        chk("periph reset", 32'h1, {31'h0, periph_reset_o});
        rdchk(DATA_ADDR, "standby read", 32'h09);
        sw_standby_i <= 1'b0;
        periph_i <= periph_out_t'(8'h00);
        $display("test software standby done");
        // Slave mode host requests on bits 5..3
        slave_mode_i <= 1'b1;
        host_irq_i <= host_irq_t'(3'b101);
        wb(1'b1, DIR_ADDR, 8'h38, 4'h1);
        settle;
        chk("oe slave", 32'h38, {24'h0, pin_oe_o});
        chk("pin slave", 32'h28, {24'h0, pin_o & 8'h38});
        chk("timer slave", 32'hd, {28'h0, timer_in_o});
        rdchk(DATA_ADDR, "slave read", 32'h21);
        // Slave mode pins set as inputs are plain inputs
        wb(1'b1, DIR_ADDR, 8'h00, 4'h1);
        settle;
        chk("oe slave input", 32'h0, {24'h0, pin_oe_o});
        rdchk(DATA_ADDR, "slave input read", 32'h09);
        slave_mode_i <= 1'b0;
        $display("test slave mode done");
        // Hardware standby clears both registers; drive all pins first
        wb(1'b1, DIR_ADDR, 8'hff, 4'h1);
        hw_standby_i <= 1'b1;
        settle;
        chk("oe hw standby", 32'h0, {24'h0, pin_oe_o});
        hw_standby_i <= 1'b0;
        wb(1'b1, DIR_ADDR, 8'hff, 4'h1);
        rdchk(DATA_ADDR, "data hw standby", 32'h0);
        $display("test hardware standby done");
        final_report;
    end
endmodule : io_port_test
